//--- core/frwp_pkg.sv
// Constants of the flash reset and write-protect host controller.
// Assumes a single 250 MHz clock; all counts are in cycles of it.
package frwp_pkg;
  localparam int CLK_MHZ       = 250;
  localparam int CNT_W         = 32;
  // Least times, rounded up
  localparam int RST_PULSE_NS  = 100;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRUP_HOLD_NS = 100;
  localparam int PWRUP_CYC     = (PWRUP_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int VPP_SETUP_NS  = 100;
  localparam int VPP_SETUP_CYC = (VPP_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_PULSE_NS   = 50;
  localparam int WE_PULSE_CYC  = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVERY_NS   = 100;
  localparam int RECOVERY_CYC  = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
  // Longest times, rounded down
  localparam int BUSY_RISE_NS  = 100;
  localparam int BUSY_RISE_CYC = BUSY_RISE_NS * CLK_MHZ / 1000;
  localparam int ABORT_US      = 22;
  localparam int ABORT_CYC     = ABORT_US * CLK_MHZ;
  localparam int PSUSP_LOW_US  = 8;
  localparam int PSUSP_LOW_CYC = PSUSP_LOW_US * CLK_MHZ;
  localparam int PSUSP_HI_US   = 7;
  localparam int PSUSP_HI_CYC  = PSUSP_HI_US * CLK_MHZ;
  localparam int ESUSP_LOW_US  = 22;
  localparam int ESUSP_LOW_CYC = ESUSP_LOW_US * CLK_MHZ;
  localparam int ESUSP_HI_US   = 14;
  localparam int ESUSP_HI_CYC  = ESUSP_HI_US * CLK_MHZ;
  // Watchdogs on word-mode operation time
  localparam int PROG_WAIT_US  = 46;
  localparam int PROG_WAIT_CYC = PROG_WAIT_US * CLK_MHZ;
  localparam int ERASE_WAIT_MS = 1140;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_MS * CLK_MHZ * 1000;
  // Block classes
  localparam logic [1:0] BLK_MAIN  = 2'h0;
  localparam logic [1:0] BLK_PARAM = 2'h1;
  localparam logic [1:0] BLK_BOOT  = 2'h2;
  typedef enum logic [3:0] {
    S_PWRUP     = 4'h0,
    S_IDLE      = 4'h1,
    S_RST       = 4'h2,
    S_RECOV     = 4'h3,
    S_SETUP     = 4'h4,
    S_STROBE    = 4'h5,
    S_BUSYWAIT  = 4'h6,
    S_BUSY      = 4'h7,
    S_SUSP      = 4'h8,
    S_SUSPENDED = 4'h9
  } frwp_state_t;
endpackage

//--- core/frwp_ctrl.sv
// Host controller driving a NOR flash reset, write-protect, program
// supply and write strobe pins, and watching its ready/busy pin.
// Assumes address and data lines are driven elsewhere.
`timescale 1ns/10ps
module frwp_ctrl #(
  parameter int ABORT_CYC      = frwp_pkg::ABORT_CYC,
  parameter int ESUSP_LOW_CYC  = frwp_pkg::ESUSP_LOW_CYC,
  parameter int PROG_WAIT_CYC  = frwp_pkg::PROG_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = frwp_pkg::ERASE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // User requests
  input  wire logic       op_start,
  input  wire logic       op_erase,
  input  wire logic [1:0] op_block,
  input  wire logic       byte_mode,
  input  wire logic       supply_high,
  input  wire logic       wp_lock,
  input  wire logic       boot_unlock,
  input  wire logic       suspend_req,
  input  wire logic       resume_req,
  input  wire logic       reset_req,
  // User status
  output logic            ctrl_ready,
  output logic            op_done,
  output logic            op_refused,
  output logic            op_timeout,
  output logic            suspend_done,
  output logic            suspend_late,
  output logic            reset_done,
  output logic            reset_fault,
  output logic            contents_undefined,
  // Pins from the board
  input  wire logic       ready_busy_n,
  input  wire logic       power_good,
  input  wire logic       supply_ok,
  // Pins to the flash
  output logic            reset_powerdown_n,
  output logic            reset_high_voltage_en,
  output logic            write_protect_n,
  output logic            program_supply_en,
  output logic            program_supply_high,
  output logic            write_strobe_n
);
  localparam int CW = frwp_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 ready, 1 power good, 2 supply ok
  logic [2:0] s1, s2, s3, filt, next_filt;
  always_comb begin
    next_filt = (s2 & s3) | (filt & (s2 ^ s3));
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1   <= 3'h0;
      s2   <= 3'h0;
      s3   <= 3'h0;
      filt <= 3'h0;
    end else begin
      s1   <= {supply_ok, power_good, ready_busy_n};
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end
  wire rdy = filt[0];
  wire pg  = filt[1];
  wire sup = filt[2];

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  frwp_pkg::frwp_state_t state, next_state;
  logic [CW-1:0] tmr, next_tmr, prog_lim, susp_lim;
  logic erase_q, next_erase_q, hi_q, next_hi_q, byte_q, next_byte_q;
  logic susp_q, next_susp_q, abort_q, next_abort_q;
  logic next_rpn, next_hv, next_vpp, next_vhi, next_we_n, next_wp_n;
  logic next_done, next_ref, next_tout, next_sdone, next_slate;
  logic next_rdone, next_rfault, next_undef;

  always_comb begin
    prog_lim = erase_q ? CW'(ERASE_WAIT_CYC)
                       : (CW'(PROG_WAIT_CYC) << byte_q);
    if (erase_q) begin
      susp_lim = hi_q ? CW'(frwp_pkg::ESUSP_HI_CYC)
                      : CW'(ESUSP_LOW_CYC);
    end else begin
      susp_lim = hi_q ? CW'(frwp_pkg::PSUSP_HI_CYC)
                      : CW'(frwp_pkg::PSUSP_LOW_CYC);
    end
  end

  always_comb begin
    next_state   = state;
    next_tmr     = tmr + CW'(1);
    next_erase_q = erase_q;
    next_hi_q    = hi_q;
    next_byte_q  = byte_q;
    next_susp_q  = susp_q;
    next_abort_q = abort_q;
    next_rpn     = reset_powerdown_n;
    next_hv      = reset_high_voltage_en;
    next_vpp     = program_supply_en;
    next_vhi     = program_supply_high;
    next_we_n    = 1'b1;
    next_wp_n    = ~wp_lock;
    next_done    = 1'b0;
    next_ref     = 1'b0;
    next_tout    = 1'b0;
    next_sdone   = 1'b0;
    next_slate   = 1'b0;
    next_rdone   = 1'b0;
    next_rfault  = 1'b0;
    next_undef   = 1'b0;
    case (state)
      frwp_pkg::S_PWRUP: begin
        next_rpn = 1'b0;
        if (!pg) begin
          next_tmr = '0;
        end else if (tmr >= CW'(frwp_pkg::PWRUP_CYC)) begin
          next_rpn   = 1'b1;
          next_state = frwp_pkg::S_RECOV;
          next_tmr   = '0;
        end
      end
      frwp_pkg::S_IDLE: begin
        if (op_start) begin
          if (op_block == frwp_pkg::BLK_BOOT && wp_lock
              && !boot_unlock) begin
            next_ref = 1'b1;
          end else begin
            // Parameter and main blocks ignore write-protect
            next_hv      = op_block == frwp_pkg::BLK_BOOT
                           && boot_unlock;
            next_vpp     = 1'b1;
            next_vhi     = supply_high;
            next_erase_q = op_erase;
            next_hi_q    = supply_high;
            next_byte_q  = byte_mode;
            next_susp_q  = 1'b0;
            next_state   = frwp_pkg::S_SETUP;
            next_tmr     = '0;
          end
        end
      end
      frwp_pkg::S_SETUP: begin
        // Covers supply and high-voltage setup before the strobe falls
        if (tmr >= CW'(frwp_pkg::VPP_SETUP_CYC)) begin
          next_tmr = '0;
          if (!sup) begin
            next_ref   = 1'b1;
            next_vpp   = 1'b0;
            next_hv    = 1'b0;
            next_state = frwp_pkg::S_IDLE;
          end else begin
            next_we_n  = 1'b0;
            next_state = frwp_pkg::S_STROBE;
          end
        end
      end
      frwp_pkg::S_STROBE: begin
        // Fixed width, registered: no glitch can reach the pin
        next_we_n = tmr >= CW'(frwp_pkg::WE_PULSE_CYC - 1);
        if (next_we_n) begin
          next_tmr   = '0;
          next_state = susp_q ? frwp_pkg::S_SUSP : frwp_pkg::S_BUSYWAIT;
        end
      end
      frwp_pkg::S_BUSYWAIT: begin
        // Busy delayed by the synchroniser, so allow its latency too
        if (!rdy) begin
          next_state = frwp_pkg::S_BUSY;
          next_tmr   = '0;
        end else if (tmr >= CW'(frwp_pkg::BUSY_RISE_CYC + 4)) begin
          next_done  = 1'b1;
          next_vpp   = 1'b0;
          next_hv    = 1'b0;
          next_state = frwp_pkg::S_IDLE;
        end
      end
      frwp_pkg::S_BUSY: begin
        if (rdy) begin
          next_done  = 1'b1;
          next_vpp   = 1'b0;
          next_hv    = 1'b0;
          next_state = frwp_pkg::S_IDLE;
        end else if (tmr >= prog_lim) begin
          next_tout  = 1'b1;
          next_state = frwp_pkg::S_RST;
          next_tmr   = '0;
        end else if (suspend_req) begin
          next_susp_q = 1'b1;
          next_we_n   = 1'b0;
          next_state  = frwp_pkg::S_STROBE;
          next_tmr    = '0;
        end
      end
      frwp_pkg::S_SUSP: begin
        if (rdy) begin
          next_sdone = 1'b1;
          next_state = frwp_pkg::S_SUSPENDED;
        end else if (tmr >= susp_lim) begin
          next_slate = 1'b1;
          next_state = frwp_pkg::S_RST;
          next_tmr   = '0;
        end
      end
      frwp_pkg::S_SUSPENDED: begin
        if (resume_req) begin
          next_susp_q = 1'b0;
          next_we_n   = 1'b0;
          next_state  = frwp_pkg::S_STROBE;
          next_tmr    = '0;
        end
      end
      frwp_pkg::S_RST: begin
        next_rpn = 1'b0;
        next_vpp = 1'b0;
        next_hv  = 1'b0;
        if (tmr >= CW'(frwp_pkg::RST_PULSE_CYC)
            && (rdy || tmr >= CW'(ABORT_CYC))) begin
          next_rfault = !rdy;
          next_rpn    = 1'b1;
          next_state  = frwp_pkg::S_RECOV;
          next_tmr    = '0;
        end
      end
      frwp_pkg::S_RECOV: begin
        // Restart while busy shows: count from the later event
        if (!rdy) begin
          next_tmr = '0;
        end else if (tmr >= CW'(frwp_pkg::RECOVERY_CYC)) begin
          next_rdone   = 1'b1;
          next_undef   = abort_q;
          next_abort_q = 1'b0;
          next_state   = frwp_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = frwp_pkg::S_PWRUP;
      end
    endcase
    if (state != frwp_pkg::S_PWRUP && state != frwp_pkg::S_RST
        && reset_req) begin
      next_abort_q = state inside {frwp_pkg::S_STROBE, frwp_pkg::S_BUSYWAIT,
                     frwp_pkg::S_BUSY, frwp_pkg::S_SUSP,
                     frwp_pkg::S_SUSPENDED};
      next_rpn   = 1'b0;
      next_vpp   = 1'b0;
      next_hv    = 1'b0;
      next_we_n  = 1'b1;
      next_state = frwp_pkg::S_RST;
      next_tmr   = '0;
    end
    if (next_state == frwp_pkg::S_RST && state != frwp_pkg::S_RST
        && !reset_req) begin
      next_abort_q = 1'b1;
    end
    if (!pg) begin
      next_rpn   = 1'b0;
      next_vpp   = 1'b0;
      next_hv    = 1'b0;
      next_we_n  = 1'b1;
      next_state = frwp_pkg::S_PWRUP;
      next_tmr   = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state                 <= frwp_pkg::S_PWRUP;
      tmr                   <= '0;
      erase_q               <= 1'b0;
      hi_q                  <= 1'b0;
      byte_q                <= 1'b0;
      susp_q                <= 1'b0;
      abort_q               <= 1'b0;
      reset_powerdown_n     <= 1'b0;
      reset_high_voltage_en <= 1'b0;
      program_supply_en     <= 1'b0;
      program_supply_high   <= 1'b0;
      write_strobe_n        <= 1'b1;
      write_protect_n       <= 1'b0;
      op_done               <= 1'b0;
      op_refused            <= 1'b0;
      op_timeout            <= 1'b0;
      suspend_done          <= 1'b0;
      suspend_late          <= 1'b0;
      reset_done            <= 1'b0;
      reset_fault           <= 1'b0;
      contents_undefined    <= 1'b0;
    end else begin
      state                 <= next_state;
      tmr                   <= next_tmr;
      erase_q               <= next_erase_q;
      hi_q                  <= next_hi_q;
      byte_q                <= next_byte_q;
      susp_q                <= next_susp_q;
      abort_q               <= next_abort_q;
      reset_powerdown_n     <= next_rpn;
      reset_high_voltage_en <= next_hv;
      program_supply_en     <= next_vpp;
      program_supply_high   <= next_vhi;
      write_strobe_n        <= next_we_n;
      write_protect_n       <= next_wp_n;
      op_done               <= next_done;
      op_refused            <= next_ref;
      op_timeout            <= next_tout;
      suspend_done          <= next_sdone;
      suspend_late          <= next_slate;
      reset_done            <= next_rdone;
      reset_fault           <= next_rfault;
      contents_undefined    <= next_undef;
    end
  end

  assign ctrl_ready = state == frwp_pkg::S_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [CW-1:0] low_cnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= reset_powerdown_n ? '0 : low_cnt + CW'(1);
    end
  end

  sequence s_we_low;
    !write_strobe_n [*8];
  endsequence
  sequence s_idle_start;
    state == frwp_pkg::S_IDLE && op_start && !reset_req && pg;
  endsequence

  property p_rst_pulse;
    $rose(reset_powerdown_n) |-> $past(low_cnt) >= frwp_pkg::RST_PULSE_CYC;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too short");
  property p_pg_low;
    !pg |=> !reset_powerdown_n && !program_supply_en;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("reset not held while supply bad");
  property p_idle_supply;
    state == frwp_pkg::S_IDLE |-> !program_supply_en;
  endproperty
  a_idle_supply: assert property (p_idle_supply)
    else $error("program supply on while idle");
  property p_boot_lock;
    s_idle_start and (op_block == frwp_pkg::BLK_BOOT && wp_lock
    && !boot_unlock) |=> op_refused && !program_supply_en;
  endproperty
  a_boot_lock: assert property (p_boot_lock)
    else $error("locked boot block not refused");
  property p_other_open;
    s_idle_start and (op_block != frwp_pkg::BLK_BOOT)
    |=> !op_refused && state == frwp_pkg::S_SETUP;
  endproperty
  a_other_open: assert property (p_other_open)
    else $error("non-boot block refused");
  property p_hv_unlock;
    s_idle_start and (op_block == frwp_pkg::BLK_BOOT && boot_unlock)
    |=> reset_high_voltage_en && program_supply_en;
  endproperty
  a_hv_unlock: assert property (p_hv_unlock)
    else $error("boot unlock not applied");
  property p_lockout;
    state == frwp_pkg::S_SETUP && !sup && pg && !reset_req
    && tmr >= frwp_pkg::VPP_SETUP_CYC |=> op_refused && write_strobe_n;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("operation not refused under lockout");
  property p_we_width;
    $fell(write_strobe_n) |-> s_we_low;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe too narrow");
  property p_prog_limit;
    state == frwp_pkg::S_BUSY && !rdy && tmr >= prog_lim && pg
    && !reset_req |=> op_timeout ##1 !reset_powerdown_n;
  endproperty
  a_prog_limit: assert property (p_prog_limit)
    else $error("busy watchdog did not fire");
endmodule

//--- sim/frwp_flash_model.sv
// Behavioural flash device seen from the controller's pins.
// Assumes one strobe per command; the block address is not modelled.
`timescale 1ns/10ps
module frwp_flash_model (
  // Clock
  input  wire logic        ref_clk,
  // Pins from the controller
  input  wire logic        reset_powerdown_n,
  input  wire logic        write_strobe_n,
  input  wire logic        program_supply_en,
  // Test controls, in cycles
  input  wire logic [15:0] busy_len,
  input  wire logic [15:0] susp_len,
  // Pin to the controller
  output logic             ready_busy_n
);
  logic [15:0] cnt;
  logic        busy;
  logic        susp;
  logic        strobe_d;
  initial begin
    cnt = 16'h0000;
    busy = 1'b0;
    susp = 1'b0;
    strobe_d = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    strobe_d <= write_strobe_n;
    if (!reset_powerdown_n) begin
      // Abort is slow but bounded; idle reset is at once
      susp <= 1'b0;
      if (cnt > 16'h0014) cnt <= 16'h0014;
      else if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
      else busy <= 1'b0; // Back to read mode, pin released
    end else if (!strobe_d && write_strobe_n) begin
      if (busy && !susp) begin
        cnt <= susp_len; // Suspend latency
        susp <= 1'b1;
      end else begin
        busy <= program_supply_en | susp; // Locked without supply
        cnt <= busy_len;
        susp <= 1'b0;
      end
    end else if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
    else busy <= 1'b0;
  end
  assign ready_busy_n = ~busy;
endmodule

//--- sim/flash_reset_and_write_protect_test.sv
// Self-checking bench for the flash reset and write-protect controller.
// Assumes frwp_pkg is compiled first; the device is a behavioural model.
`timescale 1ns/10ps
module flash_reset_and_write_protect_test;
  logic ref_clk, rstn, op_start, op_erase, byte_mode, supply_high, wp_lock;
  logic boot_unlock, suspend_req, resume_req, reset_req, power_good;
  logic supply_ok, ctrl_ready, op_done, op_refused, op_timeout;
  logic suspend_done, suspend_late, reset_done, reset_fault, undef;
  logic ready_busy_n, flash_rst_n, hv_en, wp_n, vpp_en, vpp_hi, ws_n;
  logic [1:0]  op_block;
  logic [15:0] busy_len, susp_len;
  logic [8:0]  seen;
  int          fail_count, comparisons, cycles, wlen;
  frwp_ctrl #(.ABORT_CYC(200), .ESUSP_LOW_CYC(300), .PROG_WAIT_CYC(300),
    .ERASE_WAIT_CYC(500)) frwp_ctrl_i (.ref_clk(ref_clk), .rstn(rstn),
    .op_start(op_start), .op_erase(op_erase), .op_block(op_block),
    .byte_mode(byte_mode), .supply_high(supply_high), .wp_lock(wp_lock),
    .boot_unlock(boot_unlock), .suspend_req(suspend_req),
    .resume_req(resume_req), .reset_req(reset_req),
    .ctrl_ready(ctrl_ready), .op_done(op_done), .op_refused(op_refused),
    .op_timeout(op_timeout), .suspend_done(suspend_done),
    .suspend_late(suspend_late), .reset_done(reset_done),
    .reset_fault(reset_fault), .contents_undefined(undef),
    .ready_busy_n(ready_busy_n), .power_good(power_good),
    .supply_ok(supply_ok), .reset_powerdown_n(flash_rst_n),
    .reset_high_voltage_en(hv_en), .write_protect_n(wp_n),
    .program_supply_en(vpp_en), .program_supply_high(vpp_hi),
    .write_strobe_n(ws_n));
  frwp_flash_model frwp_flash_model_i (.ref_clk(ref_clk),
    .reset_powerdown_n(flash_rst_n), .write_strobe_n(ws_n),
    .program_supply_en(vpp_en), .busy_len(busy_len),
    .susp_len(susp_len), .ready_busy_n(ready_busy_n));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Pulses are one cycle wide, so they are latched until looked at
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    seen <= seen | {hv_en, undef, reset_fault, reset_done, suspend_late,
                    suspend_done, op_timeout, op_refused, op_done};
    if (!ws_n) wlen <= wlen + 1;
    if (cycles >= 40000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check_bit(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_int(string name, int exp, int got);
    comparisons++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic expect_pulse(string name, int idx, int lim, logic exp);
    for (int i = 0; i < lim && !seen[idx]; i++) @(negedge ref_clk);
    check_bit(name, exp, seen[idx]);
  endtask
  task automatic start_op(logic er, logic [1:0] blk, logic bm,
                          logic [15:0] blen, logic [15:0] slen);
    for (int i = 0; i < 500 && ctrl_ready !== 1'b1; i++) @(negedge ref_clk);
    op_erase = er;
    op_block = blk;
    byte_mode = bm;
    busy_len = blen;
    susp_len = slen;
    seen = 9'h000;
    wlen = 0;
    op_start = 1'b1;
    @(negedge ref_clk);
    op_start = 1'b0;
  endtask
  task automatic pulse_req(int wait_cyc, ref logic req, input int idx);
    // One cycle only: a held request is taken again in later states
    repeat (wait_cyc) @(negedge ref_clk);
    req = 1'b1;
    @(negedge ref_clk);
    req = 1'b0;
    for (int i = 0; i < 3000 && !seen[idx]; i++) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_power_up;
    repeat (20) @(negedge ref_clk);
    check_bit("rst_low_no_power", 1'b0, flash_rst_n);
    power_good = 1'b1;
    expect_pulse("powerup_done", 5, 300, 1'b1);
    check_bit("vpp_off_idle", 1'b0, vpp_en);
  endtask
  task automatic test_blocks;
    wp_lock = 1'b1;
    for (int b = 0; b < 2; b++) begin
      start_op(b[0], b[1:0], 1'b0, 16'h0064, 16'h0000);
      check_bit("wp_pin_low", 1'b0, wp_n);
      check_bit("busy_not_ready", 1'b0, ctrl_ready);
      expect_pulse("unlocked_done", 0, 600, 1'b1);
      check_bit("ready_after", 1'b1, ctrl_ready);
      check_bit("vpp_off_after", 1'b0, vpp_en);
      check_int("strobe_width", 13, wlen);
    end
    start_op(1'b0, 2'h2, 1'b0, 16'h0064, 16'h0000);
    expect_pulse("boot_refused", 1, 40, 1'b1);
    check_bit("boot_not_done", 1'b0, seen[0]);
    boot_unlock = 1'b1;
    start_op(1'b1, 2'h2, 1'b0, 16'h0064, 16'h0000);
    expect_pulse("boot_hv_done", 0, 600, 1'b1);
    check_bit("hv_applied", 1'b1, seen[8]);
    boot_unlock = 1'b0;
    wp_lock = 1'b0;
  endtask
  task automatic test_lockout;
    supply_ok = 1'b0;
    start_op(1'b0, 2'h0, 1'b0, 16'h0064, 16'h0000);
    expect_pulse("lockout_refused", 1, 100, 1'b1);
    check_bit("lockout_vpp_off", 1'b0, vpp_en);
    supply_ok = 1'b1;
  endtask
  task automatic test_byte_mode;
    start_op(1'b0, 2'h0, 1'b1, 16'h01c2, 16'h0000);
    expect_pulse("byte_done", 0, 800, 1'b1);
    check_bit("byte_no_timeout", 1'b0, seen[2]);
    start_op(1'b0, 2'h0, 1'b0, 16'h01c2, 16'h0000);
    expect_pulse("word_timeout", 2, 800, 1'b1);
    expect_pulse("timeout_flag", 7, 600, 1'b1);
  endtask
  task automatic test_suspend;
    supply_high = 1'b1;
    start_op(1'b0, 2'h1, 1'b0, 16'h0096, 16'h0064);
    check_bit("vpp_high_sel", 1'b1, vpp_hi);
    pulse_req(60, suspend_req, 3);
    check_bit("prog_susp_done", 1'b1, seen[3]);
    pulse_req(2, resume_req, 0);
    check_bit("resumed_done", 1'b1, seen[0]);
    supply_high = 1'b0;
    start_op(1'b1, 2'h0, 1'b0, 16'h01c2, 16'h0190);
    check_bit("vpp_low_sel", 1'b0, vpp_hi);
    pulse_req(60, suspend_req, 4);
    check_bit("erase_susp_late", 1'b1, seen[4]);
    expect_pulse("late_reset", 5, 600, 1'b1);
  endtask
  task automatic test_reset;
    start_op(1'b1, 2'h0, 1'b0, 16'h0190, 16'h0000);
    pulse_req(60, reset_req, 5);
    check_bit("abort_reset", 1'b1, seen[5]);
    check_bit("abort_flag", 1'b1, seen[7]);
    check_bit("abort_no_fault", 1'b0, seen[6]);
    seen = 9'h000;
    pulse_req(2, reset_req, 5);
    check_bit("idle_reset", 1'b1, seen[5]);
    check_bit("idle_no_flag", 1'b0, seen[7]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rstn, op_start, op_erase, byte_mode, supply_high, wp_lock} = 6'h00;
    {boot_unlock, suspend_req, resume_req, reset_req, power_good} = 5'h00;
    supply_ok = 1'b1;
    op_block = 2'h0;
    busy_len = 16'h0000;
    susp_len = 16'h0000;
    seen = 9'h000;
    {fail_count, comparisons, cycles, wlen} = {4{32'h0000_0000}};
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    test_power_up();
    test_blocks();
    test_lockout();
    test_byte_mode();
    test_suspend();
    test_reset();
    complete_run();
  end
endmodule
